// File: dtcc_pkg.sv
// constants for the dual timer with compare and capture
package dtcc_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_T0_CTRL  = 8'h00;
   localparam logic [7:0] OFS_T0_CNT   = 8'h04;
   localparam logic [7:0] OFS_T1_CTLA  = 8'h08;
   localparam logic [7:0] OFS_T1_CTLB  = 8'h0c;
   localparam logic [7:0] OFS_T1_CNTL  = 8'h10;
   localparam logic [7:0] OFS_T1_CNTH  = 8'h14;
   localparam logic [7:0] OFS_OCR_L    = 8'h18;
   localparam logic [7:0] OFS_OCR_H    = 8'h1c;
   localparam logic [7:0] OFS_ICR_L    = 8'h20;
   localparam logic [7:0] OFS_ICR_H    = 8'h24;
   localparam logic [7:0] OFS_FLAG     = 8'h28;
   localparam logic [7:0] OFS_MASK     = 8'h2c;
   localparam logic [7:0] OFS_MISC     = 8'h30;
   // flag and mask bit positions
   localparam int FL_T0_OVF = 0;
   localparam int FL_T1_OVF = 1;
   localparam int FL_CMP    = 2;
   localparam int FL_CAP    = 3;
   localparam int FLAG_W    = 4;
   // misc register bits
   localparam int MISC_COMPARATOR_CAPTURE_SEL = 0;
   localparam int MISC_ODIR = 1;
   // clock select encodings
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_CK   = 3'h1;
   localparam logic [2:0] CS_D8   = 3'h2;
   localparam logic [2:0] CS_D64  = 3'h3;
   localparam logic [2:0] CS_D256 = 3'h4;
   localparam logic [2:0] CS_D1K  = 3'h5;
   localparam logic [2:0] CS_EFAL = 3'h6;
   localparam logic [2:0] CS_ERIS = 3'h7;
   // prescaler masks: tick when masked bits are all ones
   localparam int PRE_W = 10;
   localparam logic [9:0] PM_D8   = 10'h007;
   localparam logic [9:0] PM_D64  = 10'h03f;
   localparam logic [9:0] PM_D256 = 10'h0ff;
   localparam logic [9:0] PM_D1K  = 10'h3ff;
   // compare output modes and pwm tops
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TGL = 2'h1;
   localparam logic [1:0] COM_CLR = 2'h2;
   localparam logic [1:0] COM_SET = 2'h3;
   localparam logic [15:0] TOP_8  = 16'h00ff;
   localparam logic [15:0] TOP_9  = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [1:0] PWM_8  = 2'h1;
   localparam logic [1:0] PWM_9  = 2'h2;
   localparam int CAP_SAMPLES = 4;
endpackage : dtcc_pkg

// File: dtcc_timer.sv
// dual timer: 8-bit counter and 16-bit compare/capture/pwm timer with wishbone slave
//
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R01: timer0 select: stop, clock, /8 /64 /256 /1024, pin falling, pin rising.
// R02: timer0 pin edges count even while that pin is an output.
// R03: timer0 counts up, is read/writable, resumes from written value next cycle.
// R04: timer1 count pin is sampled each rising clock edge before edge detection.
// R05: timer1 compares count with compare value; match may clear and drive pin.
// R06: outside pwm, mode 00 off, 01 toggle, 10 clear, 11 set on match.
// R07: compare pin driven only while its direction bit selects output.
// R08: pwm select 00 off, 01 8-bit, 10 9-bit, 11 10-bit.
// R09: in pwm clear-on-match ignored and compare modes take pwm meaning.
// R10: filter off: first sampled edge captures; on: four equal samples needed.
// R11: edge select bit 6: clear captures falling edge, set captures rising.
// R12: comparator output may replace capture pin as trigger.
// R13: clear-on-match bit 3 zeroes counter the cycle after a match.
// R14: match is detected one clock after it occurs, also with prescaling.
// R15: timer1 clock select uses the same eight encodings as timer0.
// R16: timer1 pin edges count even while that pin is an output.
// R17: reserved bits of control A 5..2 and control B 5..4 read zero.
// R18: timer1 overflow, match and capture flags in flag register, enables in mask.
// R19: capture flag sets in the cycle the count goes to capture register.
// R20: pwm counts up from zero to top 255/511/1023, then down, repeating.
// R21: pwm mode 10 clears on up match, sets on down; 11 inverse.
// R22: software writes 16-bit count high byte first, then low commits.
// R23: timer0 wraps from max to zero and sets its overflow flag.
module dtcc_timer
   import dtcc_pkg::*;
#(
   parameter int ADR_W = 8
)(
   input  wire logic             clk_i,            // 40 MHz clock
   input  wire logic             rst_i,            // sync reset, high
   input  wire logic             cyc_i,            // wishbone cycle
   input  wire logic             stb_i,            // wishbone strobe
   input  wire logic             we_i,             // write enable
   input  wire logic [ADR_W-1:0] adr_i,            // byte address
   input  wire logic [3:0]       sel_i,            // byte selects
   input  wire logic [31:0]      dat_i,            // write data
   output logic      [31:0]      dat_o,            // read data
   output logic                  ack_o,            // acknowledge
   input  wire logic             t0_count_pin_i,   // timer0 external clock
   input  wire logic             t1_count_pin_i,   // timer1 external clock
   input  wire logic             capture_input_pin_i, // capture pin
   input  wire logic             comparator_output_i, // analog comparator
   output logic                  compare_output_pin_o, // compare pin level
   output logic                  compare_output_oe_o,  // compare pin drive
   output logic      [FLAG_W-1:0] timer_flags_o    // sticky flags masked
);
   typedef struct packed {
      logic             ack;
      logic [7:0]       rdat;
      logic [2:0]       t0cs;
      logic [7:0]       t0cnt;
      logic [1:0]       com;
      logic [1:0]       pwm;
      logic             icnc;
      logic             ices;
      logic             ctc;
      logic [2:0]       t1cs;
      logic [15:0]      t1cnt;
      logic [15:0]      ocr;
      logic [15:0]      ocrbuf;
      logic [15:0]      icr;
      logic [7:0]       temp;
      logic [FLAG_W-1:0] flags;
      logic [FLAG_W-1:0] mask;
      logic             comparator_capture_sel;
      logic             odir;
      logic [PRE_W-1:0] pres;
      logic             t0smp;
      logic             t0prev;
      logic             t1smp;
      logic             t1prev;
      logic [CAP_SAMPLES-1:0] caphist;
      logic             caplvl;
      logic             eq_q;
      logic             eq_qq;
      logic             down;
      logic             oc;
   } dtcc_state_s;

   dtcc_state_s s;
   dtcc_state_s next_s;

   function automatic logic dtcc_tick(input logic [2:0] cs, input logic [PRE_W-1:0] p,
                                      input logic smp, input logic prev);
      unique case (cs)
         CS_STOP: dtcc_tick = 1'b0;
         CS_CK:   dtcc_tick = 1'b1;
         CS_D8:   dtcc_tick = (p & PM_D8) == PM_D8;
         CS_D64:  dtcc_tick = (p & PM_D64) == PM_D64;
         CS_D256: dtcc_tick = (p & PM_D256) == PM_D256;
         CS_D1K:  dtcc_tick = (p & PM_D1K) == PM_D1K;
         CS_EFAL: dtcc_tick = prev & ~smp;
         CS_ERIS: dtcc_tick = ~prev & smp;
      endcase
   endfunction : dtcc_tick

   logic        req;
   logic        wr;
   logic        next_cap_lvl;
   logic        t0_tick;
   logic        t1_tick;
   logic        pwm_on;
   logic        match_evt;
   logic        cap_evt;
   logic        all_hi;
   logic        all_lo;
   logic [15:0] top;
   logic [7:0]  adr;
   logic [7:0]  wd;
   logic [FLAG_W-1:0] set_f;

   assign req       = cyc_i & stb_i;
   assign adr       = 8'(adr_i);
   assign wd        = dat_i[7:0];
   assign wr        = req & s.ack & we_i & sel_i[0];
   assign pwm_on    = s.pwm != 2'h0;
   assign top       = (s.pwm == PWM_8) ? TOP_8 : (s.pwm == PWM_9) ? TOP_9 : TOP_10;
   assign t0_tick   = dtcc_tick(s.t0cs, s.pres, s.t0smp, s.t0prev); // R01 R02
   assign t1_tick   = dtcc_tick(s.t1cs, s.pres, s.t1smp, s.t1prev); // R15 R16 R04
   assign match_evt = s.eq_q & ~s.eq_qq;                             // R14
   assign all_hi    = &s.caphist;
   assign all_lo    = ~|s.caphist;
   // the filter holds the level until four samples agree
   assign next_cap_lvl = (s.icnc & ~(all_hi | all_lo)) ? s.caplvl : s.caphist[0]; // R10
   assign cap_evt   = (next_cap_lvl != s.caplvl) & (next_cap_lvl == s.ices);     // R11
   assign dat_o     = {24'h0, s.rdat};
   assign ack_o     = s.ack;
   assign compare_output_pin_o = s.oc;
   assign timer_flags_o        = s.flags & s.mask;

   always_comb begin
      next_s = s;
      set_f  = '0;
      next_s.ack  = req & ~s.ack;
      next_s.pres = s.pres + 1'b1;
      next_s.t0smp  = t0_count_pin_i;                               // R02
      next_s.t0prev = s.t0smp;
      next_s.t1smp  = t1_count_pin_i;                               // R04
      next_s.t1prev = s.t1smp;
      // capture source and sample history
      next_s.caphist = {s.caphist[CAP_SAMPLES-2:0],
                        s.comparator_capture_sel ? comparator_output_i : capture_input_pin_i}; // R12
      next_s.caplvl = next_cap_lvl;                                 // R10

      // timer0
      if (t0_tick) begin
         next_s.t0cnt = s.t0cnt + 1'b1;                             // R03
         if (&s.t0cnt) begin
            set_f[FL_T0_OVF] = 1'b1;                                // R23
         end
      end

      // timer1 compare tracking
      next_s.eq_q  = s.t1cnt == s.ocr;                              // R05
      next_s.eq_qq = s.eq_q;
      if (pwm_on) begin
         if (t1_tick) begin
            if (!s.down) begin
               if (s.t1cnt >= top) begin
                  next_s.down  = 1'b1;                              // R20
                  next_s.t1cnt = s.t1cnt - 1'b1;
                  next_s.ocr   = s.ocrbuf & top;
               end else begin
                  next_s.t1cnt = s.t1cnt + 1'b1;
               end
            end else if (s.t1cnt == 16'h0) begin
               next_s.down  = 1'b0;                                 // R20
               next_s.t1cnt = s.t1cnt + 1'b1;
               set_f[FL_T1_OVF] = 1'b1;
            end else begin
               next_s.t1cnt = s.t1cnt - 1'b1;
            end
         end
         if (match_evt & s.com[1]) begin
            next_s.oc = s.com[0] ^ s.down;                          // R21 R09
         end
      end else begin
         next_s.down = 1'b0;
         if (match_evt & s.ctc) begin
            next_s.t1cnt = 16'h0;                                   // R13
         end else if (t1_tick) begin
            next_s.t1cnt = s.t1cnt + 1'b1;
            if (&s.t1cnt) begin
               set_f[FL_T1_OVF] = 1'b1;                             // R18
            end
         end
         if (match_evt) begin
            unique case (s.com)                                     // R06
               COM_OFF: next_s.oc = s.oc;
               COM_TGL: next_s.oc = ~s.oc;
               COM_CLR: next_s.oc = 1'b0;
               COM_SET: next_s.oc = 1'b1;
            endcase
         end
      end
      if (match_evt) begin
         set_f[FL_CMP] = 1'b1;                                      // R18
      end
      if (cap_evt) begin
         next_s.icr    = s.t1cnt;                                   // R11
         set_f[FL_CAP] = 1'b1;                                      // R19
      end

      // register reads, latched in the request cycle
      if (req & ~s.ack & ~we_i) begin
         unique case (adr)
            OFS_T0_CTRL: next_s.rdat = {5'h0, s.t0cs};
            OFS_T0_CNT:  next_s.rdat = s.t0cnt;
            OFS_T1_CTLA: next_s.rdat = {s.com, 4'h0, s.pwm};        // R17
            OFS_T1_CTLB: next_s.rdat = {s.icnc, s.ices, 2'h0, s.ctc, s.t1cs}; // R17
            OFS_T1_CNTL: begin
               next_s.rdat = s.t1cnt[7:0];
               next_s.temp = s.t1cnt[15:8];
            end
            OFS_ICR_L: begin
               next_s.rdat = s.icr[7:0];
               next_s.temp = s.icr[15:8];
            end
            OFS_T1_CNTH: next_s.rdat = s.temp;
            OFS_ICR_H:   next_s.rdat = s.temp;
            OFS_OCR_L:   next_s.rdat = s.ocrbuf[7:0];
            OFS_OCR_H:   next_s.rdat = s.ocrbuf[15:8];
            OFS_FLAG:    next_s.rdat = {4'h0, s.flags};
            OFS_MASK:    next_s.rdat = {4'h0, s.mask};
            OFS_MISC:    next_s.rdat = {6'h0, s.odir, s.comparator_capture_sel};
            default:     next_s.rdat = 8'h0;
         endcase
      end

      // register writes take effect on the acknowledged edge
      if (wr) begin
         unique case (adr)
            OFS_T0_CTRL: next_s.t0cs  = wd[2:0];                    // R01
            OFS_T0_CNT:  next_s.t0cnt = wd;                         // R03
            OFS_T1_CTLA: begin
               next_s.com = wd[7:6];                                // R06
               next_s.pwm = wd[1:0];                                // R08
            end
            OFS_T1_CTLB: begin
               next_s.icnc = wd[7];                                 // R10
               next_s.ices = wd[6];                                 // R11
               next_s.ctc  = wd[3];                                 // R13
               next_s.t1cs = wd[2:0];                               // R15
            end
            OFS_T1_CNTH: next_s.temp  = wd;                         // R22
            OFS_OCR_H:   next_s.temp  = wd;
            OFS_T1_CNTL: next_s.t1cnt = {s.temp, wd};               // R22
            OFS_OCR_L: begin
               next_s.ocrbuf = {s.temp, wd};
               if (!pwm_on) begin
                  next_s.ocr = {s.temp, wd};
               end
            end
            OFS_MASK:    next_s.mask  = wd[FLAG_W-1:0];             // R18
            OFS_MISC: begin
               next_s.comparator_capture_sel = wd[MISC_COMPARATOR_CAPTURE_SEL];                         // R12
               next_s.odir = wd[MISC_ODIR];                         // R07
            end
            default: ;
         endcase
      end
      // flags clear by writing one; a new event in the same cycle wins
      next_s.flags = s.flags;
      if (wr && adr == OFS_FLAG) begin
         next_s.flags = s.flags & ~wd[FLAG_W-1:0];
      end
      next_s.flags = next_s.flags | set_f;                          // R18
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= '0;
         // count and compare value both reset to zero, so the match detector starts already equal
         s.eq_q  <= 1'b1;
         s.eq_qq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // pin reaches the port only with direction set and a connected mode
   assign compare_output_oe_o = s.odir & (pwm_on ? s.com[1] : (s.com != COM_OFF)); // R07 R09

   default clocking dtcc_cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence dtcc_t0_wrap_seq;
      (s.t0cnt == 8'hff) && t0_tick && !wr;
   endsequence
   sequence dtcc_match_seq;
      !pwm_on && s.ctc && (s.t1cnt == s.ocr) && !s.eq_q && !wr;
   endsequence
   sequence dtcc_pin_src_seq;
      !s.comparator_capture_sel && !$past(s.comparator_capture_sel, 1) && !$past(s.comparator_capture_sel, 2) && !$past(s.comparator_capture_sel, 3) && !$past(s.comparator_capture_sel, 4);
   endsequence

   a_t0_stop_hold: assert property ((s.t0cs == CS_STOP) && !wr |=> $stable(s.t0cnt)) // R01
      else $error("timer0 moved while stopped");
   a_t0_clk_count: assert property ((s.t0cs == CS_CK) && !wr |=> s.t0cnt == $past(s.t0cnt) + 8'h1) // R03
      else $error("timer0 did not count on clock");
   a_t0_wrap_flag: assert property (dtcc_t0_wrap_seq |=> s.t0cnt == 8'h0 && s.flags[FL_T0_OVF]) // R23
      else $error("timer0 wrap missed");
   a_ctc_clear: assert property (dtcc_match_seq ##1 (!wr && !pwm_on && s.ctc) |=> s.t1cnt == 16'h0) // R13
      else $error("counter not cleared after match");
   a_cap_flag_icr: assert property (cap_evt |=> s.flags[FL_CAP] && s.icr == $past(s.t1cnt)) // R19
      else $error("capture flag and value out of step");
   a_cap_filter: assert property (dtcc_pin_src_seq ##0 (s.icnc && cap_evt) |-> // R10
      $past(capture_input_pin_i, 1) == s.ices && $past(capture_input_pin_i, 2) == s.ices &&
      $past(capture_input_pin_i, 3) == s.ices && $past(capture_input_pin_i, 4) == s.ices)
      else $error("filtered capture without four equal samples");
   a_ctla_reserved: assert property (req && !s.ack && !we_i && adr == OFS_T1_CTLA |=> s.rdat[5:2] == 4'h0) // R17
      else $error("reserved bits not zero");
   a_pwm_top: assert property (pwm_on && !wr && $stable(s.pwm) && s.t1cnt <= top |=> s.t1cnt <= top) // R20
      else $error("pwm count past top");
   a_oc_gate: assert property (!s.odir |-> !compare_output_oe_o) // R07
      else $error("compare pin driven as input");
   a_oc_toggle: assert property (!pwm_on && match_evt && s.com == COM_TGL |=> s.oc != $past(s.oc)) // R06
      else $error("compare toggle missed");
   a_wb_ack: assert property (s.ack |=> !s.ack)
      else $error("ack longer than one cycle");

   // counting, compare output, pwm, capture, register and bus checks
   a_t1_stop_hold: assert property (!pwm_on && s.t1cs == CS_STOP && !(match_evt && s.ctc) && !wr // R15
      |=> $stable(s.t1cnt)) else $error("timer1 moved while stopped");
   a_t1_clk_count: assert property (!pwm_on && s.t1cs == CS_CK && !(match_evt && s.ctc) && !wr // R15
      |=> s.t1cnt == $past(s.t1cnt) + 16'h1) else $error("timer1 did not count on clock");
   a_t1_pin_rise: assert property (!pwm_on && !s.ctc && s.t1cs == CS_ERIS && !wr // R04 R16
      && !$past(t1_count_pin_i, 2) && $past(t1_count_pin_i, 1)
      |=> s.t1cnt == $past(s.t1cnt) + 16'h1) else $error("timer1 missed a pin edge");
   a_t0_pin_fall: assert property (s.t0cs == CS_EFAL && !wr // R02
      && $past(t0_count_pin_i, 2) && !$past(t0_count_pin_i, 1)
      |=> s.t0cnt == $past(s.t0cnt) + 8'h1) else $error("timer0 missed a pin edge");
   a_t0_wr_load: assert property (wr && adr == OFS_T0_CNT |=> s.t0cnt == $past(wd)) // R03
      else $error("timer0 write lost");
   a_t1_ovf_flag: assert property (!pwm_on && !(match_evt && s.ctc) && t1_tick && !wr // R18
      && s.t1cnt == 16'hffff |=> s.t1cnt == 16'h0 && s.flags[FL_T1_OVF]) else $error("timer1 wrap missed");
   a_cnt_commit: assert property (wr && adr == OFS_T1_CNTL |=> s.t1cnt == {$past(s.temp), $past(wd)}) // R22
      else $error("16-bit count write not committed");
   a_ocr_direct: assert property (wr && adr == OFS_OCR_L && !pwm_on |=> s.ocr == {$past(s.temp), $past(wd)}) // R05
      else $error("compare value write not committed");
   a_match_pulse: assert property (match_evt |=> !match_evt && s.flags[FL_CMP]) // R14 R18
      else $error("match event not a single flagged pulse");
   a_oc_hold: assert property (!match_evt |=> $stable(s.oc)) // R05
      else $error("compare output moved without a match");
   a_oc_set: assert property (!pwm_on && match_evt && s.com == COM_SET |=> s.oc) // R06
      else $error("compare set missed");
   a_oc_clear: assert property (!pwm_on && match_evt && s.com == COM_CLR |=> !s.oc) // R06
      else $error("compare clear missed");
   a_pwm_up_clr: assert property (pwm_on && match_evt && s.com == COM_CLR && !s.down |=> !s.oc) // R21
      else $error("pwm up-count match did not clear");
   a_pwm_down_set: assert property (pwm_on && match_evt && s.com == COM_CLR && s.down |=> s.oc) // R21
      else $error("pwm down-count match did not set");
   a_pwm_bottom: assert property (pwm_on && t1_tick && s.down && s.t1cnt == 16'h0 && !wr // R20
      |=> !s.down && s.t1cnt == 16'h1 && s.flags[FL_T1_OVF]) else $error("pwm bottom turn missed");
   a_pwm_no_ctc: assert property (pwm_on && s.ctc && match_evt && !t1_tick && !wr |=> $stable(s.t1cnt)) // R09
      else $error("pwm count cleared on match");
   a_pwm_oe_off: assert property (pwm_on && !s.com[1] |-> !compare_output_oe_o) // R09
      else $error("pwm pin driven while not connected");
   a_ctlb_reserved: assert property (req && !s.ack && !we_i && adr == OFS_T1_CTLB |=> s.rdat[5:4] == 2'h0) // R17
      else $error("reserved bits not zero");
   a_icr_hold: assert property (!cap_evt |=> $stable(s.icr)) // R11
      else $error("capture value moved without an event");
   a_mask_gate: assert property (!s.mask[FL_CAP] |-> !timer_flags_o[FL_CAP]) // R18
      else $error("capture flag passed a clear mask");
   a_wb_answer: assert property (req && !s.ack |=> s.ack)
      else $error("request not answered next cycle");
endmodule : dtcc_timer
`default_nettype wire

// File: dtcc_cpu_model.sv
// wishbone master model standing in for the cpu core
`timescale 1ns/10ps
`default_nettype none
module dtcc_cpu_model (
   input  wire logic        clk_i, // clock
   input  wire logic [31:0] dat_i, // read data
   input  wire logic        ack_i, // acknowledge
   output logic             cyc_o, // cycle
   output logic             stb_o, // strobe
   output logic             we_o,  // write enable
   output logic [7:0]       adr_o, // byte address
   output logic [3:0]       sel_o, // byte selects
   output logic [31:0]      dat_o  // write data
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   // one classic cycle, held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= 4'h1;
      dat_o <= {24'h0, d};
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      q = dat_i[7:0];
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // released data no longer shows the last value
      dat_o <= ~dat_o;
   endtask : xfer
endmodule : dtcc_cpu_model
`default_nettype wire

// File: testbench.sv
// register-level bench for the dual timer
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import dtcc_pkg::*;
   logic        clk_i;
   logic        rst_i;
   logic [3:0]  pin;
   logic        cyc, stb, we, ack, opin, oe;
   logic [7:0]  adr, q;
   logic [3:0]  sel, flg;
   logic [31:0] wd, rdat;
   int          miscompares, checks;
   logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h28, 8'h2c, 8'h30, 8'h3c};
   logic [7:0]  cm = 8'h79;
   logic [3:0]  ep = 4'b0101;
   int          dv [6] = '{0, 1, 8, 64, 256, 1024};
   dtcc_cpu_model cpu (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
   dtcc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
      .t0_count_pin_i(pin[0]), .t1_count_pin_i(pin[1]), .capture_input_pin_i(pin[2]),
      .comparator_output_i(pin[3]), .compare_output_pin_o(opin), .compare_output_oe_o(oe),
      .timer_flags_o(flg));
   task automatic end_of_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cpu.xfer(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
      cpu.xfer(1'b0, a, 8'h00, q);
      chk(n, {8'h0, e}, {8'h0, q});
   endtask : rd
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a + 8'h04, d[15:8]);
      wr(a, d[7:0]);
   endtask : wr16
   task automatic rd16(input logic [7:0] a, input logic [15:0] e, input string n);
      rd(a, e[7:0], n);
      rd(a + 8'h04, e[15:8], n);
   endtask : rd16
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         @(posedge clk_i);
         pin[i] <= 1'b1;
         repeat (5) @(posedge clk_i);
         pin[i] <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
   endtask : pulse
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   initial begin
      repeat (80000) @(posedge clk_i);
      miscompares++;
      end_of_test();
   end
   initial begin
      int w, lo, hi;
      rst_i = 1'b1;
      pin = 4'h0;
      miscompares = 0;
      checks = 0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wr(8'h3c, 8'hff);
      foreach (ra[k]) rd(ra[k], 8'h00, "reset value");
      wr(8'h08, 8'hff);
      rd(8'h08, 8'hc3, "control a");
      wr(8'h0c, 8'hff);
      rd(8'h0c, 8'hcf, "control b");
      wr(8'h0c, 8'h00);
      wr(8'h08, 8'h00);
      $display("test registers done");
      for (int t = 0; t < 2; t++) begin
         for (int c = 0; c < 6; c++) begin
            w = (dv[c] < 8) ? 32 : 4 * dv[c];
            lo = dv[c] ? w / dv[c] : 0;
            hi = dv[c] ? (w + 6) / dv[c] + 1 : 0;
            wr16(8'h10, 16'h0000);
            wr(8'h04, 8'h00);
            wr(t ? 8'h0c : 8'h00, c[7:0]);
            repeat (w) @(posedge clk_i);
            wr(t ? 8'h0c : 8'h00, 8'h00);
            cpu.xfer(1'b0, t ? 8'h10 : 8'h04, 8'h00, q);
            chk("prescaled count in range", 16'h0001, {15'h0, q >= lo && q <= hi});
         end
      end
      $display("test prescaler done");
      wr(8'h28, 8'h0f);
      wr(8'h04, 8'hfe);
      rd(8'h04, 8'hfe, "t0 count");
      wr(8'h00, 8'h07);
      pulse(0, 3);
      rd(8'h04, 8'h01, "t0 count");
      rd(8'h28, 8'h01, "flags");
      wr(8'h00, 8'h06);
      pulse(0, 2);
      rd(8'h04, 8'h03, "t0 count");
      wr(8'h00, 8'h00);
      wr(8'h28, 8'h0f);
      $display("test timer0 pin done");
      wr(8'h0c, 8'h40);
      wr16(8'h10, 16'h0abc);
      pulse(2, 1);
      rd16(8'h20, 16'h0abc, "capture");
      rd(8'h28, 8'h08, "flags");
      chk("masked flags", 16'h0000, {12'h0, flg});
      wr(8'h2c, 8'h0f);
      rd(8'h28, 8'h08, "flags");
      chk("masked flags", 16'h0008, {12'h0, flg});
      wr(8'h28, 8'h0f);
      wr(8'h0c, 8'h00);
      pin[2] <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(8'h28, 8'h00, "flags");
      wr16(8'h10, 16'h0123);
      pin[2] <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd16(8'h20, 16'h0123, "capture");
      wr(8'h28, 8'h0f);
      wr(8'h0c, 8'hc0);
      wr16(8'h10, 16'h0456);
      // three equal samples must not pass the filter
      pin[2] <= 1'b1;
      repeat (3) @(posedge clk_i);
      pin[2] <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(8'h28, 8'h00, "flags");
      pulse(2, 1);
      rd16(8'h20, 16'h0456, "capture");
      wr(8'h30, 8'h01);
      wr(8'h0c, 8'h40);
      wr16(8'h10, 16'h0789);
      pulse(3, 1);
      rd16(8'h20, 16'h0789, "capture");
      $display("test capture done");
      wr(8'h28, 8'h0f);
      wr(8'h30, 8'h02);
      wr16(8'h18, 16'h0005);
      rd16(8'h18, 16'h0005, "compare value");
      wr16(8'h10, 16'h0000);
      wr(8'h0c, 8'h0f);
      for (int k = 0; k < 4; k++) begin
         wr(8'h08, {cm[2*k+:2], 6'h00});
         pulse(1, 5);
         rd16(8'h10, 16'h0000, "cleared count");
         chk("compare pin", {15'h0, ep[k]}, {15'h0, opin});
         chk("compare drive", 16'h0001, {15'h0, oe});
      end
      chk("masked flags", 16'h0004, {12'h0, flg});
      wr(8'h08, 8'h00);
      @(negedge clk_i);
      chk("compare drive", 16'h0000, {15'h0, oe});
      wr(8'h08, 8'hc0);
      wr(8'h30, 8'h00);
      @(negedge clk_i);
      chk("compare drive", 16'h0000, {15'h0, oe});
      wr(8'h0c, 8'h07);
      wr16(8'h10, 16'h0000);
      pulse(1, 7);
      rd16(8'h10, 16'h0007, "count");
      wr16(8'h10, 16'hfffe);
      pulse(1, 3);
      rd16(8'h10, 16'h0001, "count");
      rd(8'h28, 8'h06, "flags");
      $display("test compare done");
      wr(8'h0c, 8'h00);
      for (int r = 1; r < 4; r++) begin
         w = (128 << r) - 1;
         wr(8'h08, r[7:0]);
         wr16(8'h10, 16'h0000);
         wr(8'h0c, 8'h0f);
         pulse(1, w + 3);
         rd16(8'h10, w[15:0] - 16'h0003, "pwm count");
         wr(8'h0c, 8'h00);
      end
      wr(8'h30, 8'h02);
      wr(8'h08, 8'h81);
      wr16(8'h18, 16'h0080);
      wr16(8'h10, 16'h0000);
      wr(8'h0c, 8'h07);
      pulse(1, 411);
      rd16(8'h10, 16'h0063, "pwm count");
      chk("compare pin", 16'h0001, {15'h0, opin});
      pulse(1, 299);
      rd16(8'h10, 16'h00c8, "pwm count");
      chk("compare pin", 16'h0000, {15'h0, opin});
      $display("test pwm done");
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
